// *** rtl/mdsr_regs.vh ***
// Offsets, field positions, reset values and timing counts of the
// motor driver status register bank.
// Assumes inclusion by its bare name from the design file only.
`ifndef MDSR_REGS_VH
`define MDSR_REGS_VH

// ****************************************
// Register offsets (serial address field)
// ****************************************
`define MDSR_ADDR_SUMMARY 6'h00
`define MDSR_ADDR_DIAG1 6'h01
`define MDSR_ADDR_DIAG2 6'h02
`define MDSR_ADDR_CTRL4 6'h06

// ****************************************
// Summary register fields
// ****************************************
`define MDSR_SUM_FAULT 7
`define MDSR_SUM_SPI_ERR 6
`define MDSR_SUM_SUPPLY 5
`define MDSR_SUM_PUMP 4
`define MDSR_SUM_OCP 3
`define MDSR_SUM_STALL 2
`define MDSR_SUM_THERMAL 1
`define MDSR_SUM_OPEN 0

// ****************************************
// Second diagnostic register fields
// ****************************************
`define MDSR_D2_COLD 7
`define MDSR_D2_HOT_WARN 6
`define MDSR_D2_HOT_SHUT 5
`define MDSR_D2_STALL 3
`define MDSR_D2_OPEN_B 1
`define MDSR_D2_OPEN_A 0

// Clear-faults bit in the fourth control register
`define MDSR_CLEAR_BIT 7

// ****************************************
// Frame layout and reset values
// ****************************************
`define MDSR_FRAME_BITS 5'd16
`define MDSR_HALF_BITS 5'd8
`define MDSR_RW_BIT 14
`define MDSR_STATUS_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define MDSR_CLK_MHZ 50
`define MDSR_SCLK_ABSENT_NS 10000

`endif

// *** rtl/mdsr_status_bank.v ***
// Status register bank of a stepper motor driver with its serial port.
// Assumes fault conditions and serial pins arrive asynchronously; the
// serial clock is slow enough (>= 4 system clocks per phase) to sample.
//
// Operation
// R1: Three read-only status registers, writes ignored
// R2: Host leaves unlisted offsets untouched
// R3: Summary bit 7 is inverse of error pin
// R4: Summary bit 6 flags serial protocol errors
// R5: Protocol error drives the error pin low
// R6: Clear needs request and condition gone
// R7: Summary bit 5 reports supply lockout
// R8: Summary bit 4 reports pump undervoltage
// R9: Summary bit 3 reports overcurrent
// R10: Summary bit 2 reports motor stall
// R11: Summary bit 1 ORs three thermal flags
// R12: Summary bit 0 reports open load
// R13: Diag bits 7..4 second bridge overcurrent
// R14: Diag bits 3..0 first bridge overcurrent
// R15: Next diag register holds thermal flags
// R16: Overcurrent summary ORs eight; reset zero
`timescale 1ns/1ps
`include "mdsr_regs.vh"
`default_nettype none

module mdsr_status_bank (
    input wire clk_i,
    input wire srst_i,
    input wire sclk_i,
    input wire chip_select_n_i,
    input wire sdi_i,
    input wire low_power_pin_n_i,
    input wire supply_low_lockout_i,
    input wire pump_undervoltage_i,
    input wire stall_flag_i,
    input wire hot_warning_i,
    input wire cold_warning_i,
    input wire hot_shutdown_i,
    input wire open_load_a_i,
    input wire open_load_b_i,
    input wire b_low2_overcurrent_i,
    input wire b_high2_overcurrent_i,
    input wire b_low1_overcurrent_i,
    input wire b_high1_overcurrent_i,
    input wire a_low2_overcurrent_i,
    input wire a_high2_overcurrent_i,
    input wire a_low1_overcurrent_i,
    input wire a_high1_overcurrent_i,
    output wire sdo_o,
    output wire sdo_oe_o,
    output wire error_pin_n_o
);

    // ****************************************
    // Constants
    // ****************************************
    // Cycles without a serial clock edge before a held select is an error
    localparam integer ABSENT_CYC_INT =
        (`MDSR_SCLK_ABSENT_NS * `MDSR_CLK_MHZ) / 1000;
    localparam [15:0] ABSENT_CYC = ABSENT_CYC_INT[15:0];

    // Read data for one address; unlisted offsets read zero
    function [7:0] read_mux;
        input [5:0] addr;
        input [7:0] sum;
        input [7:0] d1;
        input [7:0] d2;
        begin
            case (addr)
                `MDSR_ADDR_SUMMARY: read_mux = sum;
                `MDSR_ADDR_DIAG1: read_mux = d1;
                `MDSR_ADDR_DIAG2: read_mux = d2;
                default: read_mux = 8'h00;
            endcase
        end
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    wire [19:0] async_in; // All pins from outside this clock domain
    reg [19:0] meta_reg; // First stage, read only by second stage
    reg [19:0] sync_reg; // Second stage, safe to use

    assign async_in = {sclk_i, chip_select_n_i, sdi_i, low_power_pin_n_i,
                       supply_low_lockout_i, pump_undervoltage_i, stall_flag_i,
                       hot_warning_i, cold_warning_i, hot_shutdown_i,
                       open_load_a_i, open_load_b_i,
                       b_low2_overcurrent_i, b_high2_overcurrent_i,
                       b_low1_overcurrent_i, b_high1_overcurrent_i,
                       a_low2_overcurrent_i, a_high2_overcurrent_i,
                       a_low1_overcurrent_i, a_high1_overcurrent_i};

    // Two flops per pin; reset value is the idle level of each pin
    always @(posedge clk_i) begin
        if (srst_i) begin
            meta_reg <= 20'h50000;
            sync_reg <= 20'h50000;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    wire sclk_s = sync_reg[19]; // Synchronised serial clock
    wire csn_s = sync_reg[18]; // Synchronised select, active low
    wire sdi_s = sync_reg[17]; // Synchronised serial data in
    wire sleep_n_s = sync_reg[16]; // Synchronised low-power pin
    wire [7:0] cond_s = sync_reg[15:8]; // Summary-level conditions
    wire [7:0] ocp_s = sync_reg[7:0]; // Per-transistor overcurrent

    // ****************************************
    // Edge detection
    // ****************************************
    reg sclk_d_reg; // Previous serial clock level
    reg csn_d_reg; // Previous select level
    reg sleep_d_reg; // Previous low-power pin level

    // Delay flops on synchronised signals only
    always @(posedge clk_i) begin
        if (srst_i) begin
            sclk_d_reg <= 1'b0;
            csn_d_reg <= 1'b1;
            sleep_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            csn_d_reg <= csn_s;
            sleep_d_reg <= sleep_n_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d_reg; // Sample point
    wire sclk_fall = ~sclk_s & sclk_d_reg; // Launch point
    wire cs_fall = ~csn_s & csn_d_reg; // Frame start
    wire cs_rise = csn_s & ~csn_d_reg; // Frame end
    wire sleep_pulse = sleep_n_s & ~sleep_d_reg; // Wake after reset pulse

    // ****************************************
    // Latched status flags
    // ****************************************
    reg supply_reg; // Supply lockout latch
    reg pump_reg; // Charge pump undervoltage latch
    reg stall_reg; // Stall latch
    reg hot_warn_reg; // Overtemperature warning latch
    reg cold_reg; // Undertemperature warning latch
    reg hot_shut_reg; // Overtemperature shutdown latch
    reg open_a_reg; // Open load on first bridge
    reg open_b_reg; // Open load on second bridge
    reg [7:0] ocp_reg; // Per-transistor overcurrent latches
    reg spi_err_reg; // Serial protocol error latch
    reg error_pin_n_reg; // Error pin, low while any fault is held
    reg clear_req_reg; // One-cycle clear-faults request

    wire spi_err_set; // Protocol error event
    wire [7:0] summary; // Summary register read value
    wire [7:0] diag1; // Diagnostic register 1 read value
    wire [7:0] diag2; // Diagnostic register 2 read value
    wire any_fault; // Any latched flag

    // Flags are sticky; a set in the clear cycle wins, and a flag
    // whose condition still stands simply stays set
    always @(posedge clk_i) begin
        if (srst_i) begin
            supply_reg <= 1'b0; // R16
            pump_reg <= 1'b0;
            stall_reg <= 1'b0;
            hot_warn_reg <= 1'b0;
            cold_reg <= 1'b0;
            hot_shut_reg <= 1'b0;
            open_a_reg <= 1'b0;
            open_b_reg <= 1'b0;
            ocp_reg <= `MDSR_STATUS_RESET;
            spi_err_reg <= 1'b0;
        end else begin
            supply_reg <= cond_s[7] | (supply_reg & ~clear_req_reg); // R7
            pump_reg <= cond_s[6] | (pump_reg & ~clear_req_reg); // R8
            stall_reg <= cond_s[5] | (stall_reg & ~clear_req_reg); // R10
            hot_warn_reg <= cond_s[4] | (hot_warn_reg & ~clear_req_reg);
            cold_reg <= cond_s[3] | (cold_reg & ~clear_req_reg);
            hot_shut_reg <= cond_s[2] | (hot_shut_reg & ~clear_req_reg);
            open_a_reg <= cond_s[1] | (open_a_reg & ~clear_req_reg); // R12
            open_b_reg <= cond_s[0] | (open_b_reg & ~clear_req_reg);
            ocp_reg <= ocp_s | (ocp_reg & {8{~clear_req_reg}}); // R13 R14
            spi_err_reg <= spi_err_set | (spi_err_reg & ~clear_req_reg); // R4 R6
        end
    end

    // Error pin tracks held faults, protocol error included
    assign any_fault = supply_reg | pump_reg | stall_reg | hot_warn_reg |
                       cold_reg | hot_shut_reg | open_a_reg | open_b_reg |
                       (|ocp_reg) | spi_err_reg;

    always @(posedge clk_i) begin
        if (srst_i) begin
            error_pin_n_reg <= 1'b1;
        end else begin
            error_pin_n_reg <= ~any_fault; // R5
        end
    end

    // Bit 7 read from the pin flop itself, so both always agree
    assign summary = {~error_pin_n_reg, // R3
                      spi_err_reg, // R4
                      supply_reg, // R7
                      pump_reg, // R8
                      |ocp_reg, // R9 R16
                      stall_reg, // R10
                      hot_warn_reg | cold_reg | hot_shut_reg, // R11
                      open_a_reg | open_b_reg}; // R12
    assign diag1 = ocp_reg; // R13 R14
    assign diag2 = {cold_reg, hot_warn_reg, hot_shut_reg, 1'b0, // R15
                    stall_reg, 1'b0, open_b_reg, open_a_reg};

    // ****************************************
    // Serial port
    // ****************************************
    // Frame: 16 bits MSB first, sampled on rising, launched on falling.
    // In: bit 15 zero, bit 14 one for read, bits 13:8 address, 7:0 data.
    // Out: summary byte, then the addressed register.
    reg [4:0] bit_cnt_reg; // Rising edges seen, saturating
    reg [15:0] rx_reg; // Received bits
    reg [7:0] tx_reg; // Bits still to send
    reg sdo_reg; // Serial data out
    reg sdo_oe_reg; // Drive enable, high inside a frame
    reg [15:0] idle_cnt_reg; // Cycles since the last clock edge
    reg timeout_hit_reg; // Absent-clock error already raised this frame

    wire [15:0] rx_next = {rx_reg[14:0], sdi_s}; // Shift in one bit
    wire frame_ok = (bit_cnt_reg == `MDSR_FRAME_BITS); // Exact length
    wire is_read = rx_reg[`MDSR_RW_BIT]; // Read or write command
    wire [5:0] rx_addr = rx_reg[13:8]; // Addressed register at frame end
    // Mid-frame only eight bits are in, so the address sits low
    wire [5:0] hdr_addr = rx_reg[5:0]; // Addressed register after 8 bits
    wire [7:0] rd_data = read_mux(hdr_addr, summary, diag1, diag2);
    wire timeout = ~csn_s & ~timeout_hit_reg & (idle_cnt_reg >= ABSENT_CYC);

    // Too many or too few clocks, or a held select with no clock
    assign spi_err_set = (cs_rise & ~frame_ok) | timeout; // R4

    // Shifting and framing
    always @(posedge clk_i) begin
        if (srst_i) begin
            bit_cnt_reg <= 5'd0;
            rx_reg <= 16'h0000;
            tx_reg <= 8'h00;
            sdo_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
        end else if (cs_fall) begin
            // First bit stands as soon as the frame opens
            bit_cnt_reg <= 5'd0;
            sdo_reg <= summary[7];
            tx_reg <= {summary[6:0], 1'b0};
            sdo_oe_reg <= 1'b1;
        end else if (csn_s) begin
            // Release the line between frames
            sdo_oe_reg <= 1'b0;
            sdo_reg <= 1'b0;
        end else if (sclk_rise) begin
            rx_reg <= rx_next;
            if (bit_cnt_reg != 5'd31) begin
                bit_cnt_reg <= bit_cnt_reg + 5'd1;
            end
        end else if (sclk_fall) begin
            if (bit_cnt_reg == `MDSR_HALF_BITS) begin
                // Address is complete; send the addressed register
                sdo_reg <= rd_data[7];
                tx_reg <= {rd_data[6:0], 1'b0};
            end else begin
                sdo_reg <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // Absent-clock watchdog, raised once per frame
    always @(posedge clk_i) begin
        if (srst_i) begin
            idle_cnt_reg <= 16'h0000;
            timeout_hit_reg <= 1'b0;
        end else if (csn_s | sclk_rise | sclk_fall) begin
            idle_cnt_reg <= 16'h0000;
            if (csn_s) begin
                timeout_hit_reg <= 1'b0;
            end
        end else begin
            if (idle_cnt_reg != 16'hffff) begin
                idle_cnt_reg <= idle_cnt_reg + 16'h0001;
            end
            if (timeout) begin
                timeout_hit_reg <= 1'b1;
            end
        end
    end

    // Clear request from a good write of the clear bit or a wake pulse.
    // Writes to the status offsets fall through and change nothing.
    always @(posedge clk_i) begin
        if (srst_i) begin
            clear_req_reg <= 1'b0;
        end else begin
            clear_req_reg <= sleep_pulse | // R6
                (cs_rise & frame_ok & ~is_read & ~timeout_hit_reg &
                 (rx_addr == `MDSR_ADDR_CTRL4) &
                 rx_reg[`MDSR_CLEAR_BIT]); // R1 R6
        end
    end

    assign sdo_o = sdo_reg;
    assign sdo_oe_o = sdo_oe_reg;
    assign error_pin_n_o = error_pin_n_reg;

endmodule

`default_nettype wire

// *** sim/mdsr_status_bank_sva.sv ***
// Concurrent checks on the pins of the status register bank.
// Assumes it is bound into mdsr_status_bank and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mdsr_checker (
    input wire clk_i,
    input wire srst_i,
    input wire sclk_i,
    input wire chip_select_n_i,
    input wire low_power_pin_n_i,
    input wire supply_low_lockout_i,
    input wire pump_undervoltage_i,
    input wire stall_flag_i,
    input wire hot_warning_i,
    input wire cold_warning_i,
    input wire hot_shutdown_i,
    input wire sdo_o,
    input wire sdo_oe_o,
    input wire error_pin_n_o
);
    // ****************
    // Helper counters
    // ****************
    logic sclk_q; // Serial clock one cycle ago
    logic [3:0] quiet_cnt; // Cycles with no clear source active
    logic [9:0] idle_cnt; // Selected cycles with no clock edge
    // Both saturate so a long idle spell never wraps to zero
    always @(posedge clk_i) begin
        sclk_q <= sclk_i;
        if (srst_i || !chip_select_n_i || !low_power_pin_n_i) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hf) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
        if (srst_i || chip_select_n_i || sclk_q != sclk_i) begin
            idle_cnt <= 10'h000;
        end else if (idle_cnt != 10'h3ff) begin
            idle_cnt <= idle_cnt + 10'h001;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // ****************
    // Assertions
    // ****************
    a_reset_idle: assert property ($fell(srst_i) |-> error_pin_n_o && !sdo_oe_o)
        else $error("outputs not idle after reset");
    a_supply_pin: assert property ($rose(supply_low_lockout_i) |-> ##[1:6] !error_pin_n_o)
        else $error("supply lockout left the error pin high");
    a_pump_pin: assert property ($rose(pump_undervoltage_i) |-> ##[1:6] !error_pin_n_o)
        else $error("pump undervoltage left the error pin high");
    a_stall_pin: assert property ($rose(stall_flag_i) |-> ##[1:6] !error_pin_n_o)
        else $error("stall left the error pin high");
    a_thermal_pin: assert property ($rose(hot_warning_i | cold_warning_i | hot_shutdown_i)
        |-> ##[1:6] !error_pin_n_o) else $error("thermal flag left the error pin high");
    a_pin_sticky: assert property (quiet_cnt == 4'hf && !error_pin_n_o |=> !error_pin_n_o)
        else $error("error pin released with no clear request");
    a_absent_clock: assert property (idle_cnt == 10'h208 |-> !error_pin_n_o)
        else $error("missing serial clock not flagged");
    a_oe_frame: assert property ($fell(chip_select_n_i) |-> ##[2:5] sdo_oe_o)
        else $error("data output not enabled in frame");
    a_sdo_quiet: assert property (!sdo_oe_o |-> !sdo_o)
        else $error("data output active outside frame");
    c_supply: cover property ($rose(supply_low_lockout_i));
    c_absent: cover property (idle_cnt == 10'h208);
    c_sleep: cover property ($rose(low_power_pin_n_i));
endmodule

bind mdsr_status_bank mdsr_checker u_mdsr_checker (
    .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .chip_select_n_i(chip_select_n_i),
    .low_power_pin_n_i(low_power_pin_n_i), .supply_low_lockout_i(supply_low_lockout_i),
    .pump_undervoltage_i(pump_undervoltage_i), .stall_flag_i(stall_flag_i),
    .hot_warning_i(hot_warning_i), .cold_warning_i(cold_warning_i),
    .hot_shutdown_i(hot_shutdown_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .error_pin_n_o(error_pin_n_o)
);
`default_nettype wire

// *** sim/mdsr_spi_host.sv ***
// Host controller model that runs serial frames on the status bank.
// Assumes a 50 MHz clock; the serial clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module mdsr_spi_host (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic sclk_o,
    output logic chip_select_n_o,
    output logic sdi_o
);
    // ****************
    // Frame driver
    // ****************
    initial begin
        sclk_o = 1'b0;
        chip_select_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // Frames come from the bench, which never writes an unlisted offset
    // Zero bits holds select low with no clock to provoke the timeout
    task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        @(posedge clk_i);
        #1 chip_select_n_o = 1'b0;
        repeat (nbits == 0 ? 600 : 8) @(posedge clk_i);
        #1;
        // 4 clocks per phase gives a 160 ns serial period
        for (i = 0; i < nbits; i++) begin
            sdi_o = (i < 16) ? cmd[15 - i] : 1'b0;
            repeat (4) @(posedge clk_i);
            #1 sclk_o = 1'b1;
            repeat (4) @(posedge clk_i);
            // Sample late in the high phase, well after the bit settled
            #1 rx = {rx[14:0], sdo_i};
            sclk_o = 1'b0;
        end
        // Released data line shows the inverse, not a stale level
        sdi_o = ~sdi_o;
        repeat (4) @(posedge clk_i);
        #1 chip_select_n_o = 1'b1;
        repeat (12) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** sim/motor_driver_status_regs_tb.sv ***
// Self-checking bench for the status register bank.
// Assumes the checker is bound in and the host model drives the link.
`timescale 1ns/1ps
`default_nettype none
module motor_driver_status_regs_tb;
    logic clk_i = 1'b0; // 50 MHz system clock
    logic srst_i; // Synchronous reset
    logic sleep_n; // Sleep pin, pulsed low to clear
    logic [15:0] f; // Fault inputs: overcurrent high byte, others low
    logic [15:0] v; // Fault pattern of this round
    logic [15:0] rx; // Bytes returned by a frame
    wire sclk, cs_n, sdi, sdo, sdo_oe, err_n;
    int seed, k, n_errors, comparisons;
    always #10 clk_i = ~clk_i;
    mdsr_spi_host host (.clk_i(clk_i), .sdo_i(sdo), .sclk_o(sclk), .chip_select_n_o(cs_n),
        .sdi_o(sdi));
    mdsr_status_bank dut (
        .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk), .chip_select_n_i(cs_n), .sdi_i(sdi),
        .low_power_pin_n_i(sleep_n), .supply_low_lockout_i(f[7]), .pump_undervoltage_i(f[6]),
        .stall_flag_i(f[5]), .cold_warning_i(f[4]), .hot_warning_i(f[3]),
        .hot_shutdown_i(f[2]), .open_load_b_i(f[1]), .open_load_a_i(f[0]),
        .b_low2_overcurrent_i(f[15]), .b_high2_overcurrent_i(f[14]),
        .b_low1_overcurrent_i(f[13]), .b_high1_overcurrent_i(f[12]),
        .a_low2_overcurrent_i(f[11]), .a_high2_overcurrent_i(f[10]),
        .a_low1_overcurrent_i(f[9]), .a_high1_overcurrent_i(f[8]),
        .sdo_o(sdo), .sdo_oe_o(sdo_oe), .error_pin_n_o(err_n));
    // ****************
    // Expectations and bus tasks
    // ****************
    // Every flag latches, so the pin bit is set by any fault at all
    function automatic logic [7:0] exp_sum(input logic [15:0] p);
        exp_sum = {|p, 1'b0, p[7], p[6], |p[15:8], p[5], |p[4:2], |p[1:0]};
    endfunction
    function automatic logic [7:0] exp_d2(input logic [15:0] p);
        exp_d2 = {p[4], p[3], p[2], 1'b0, p[5], 1'b0, p[1], p[0]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] r);
        host.xfer({2'b01, a, 8'h00}, 16, r);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] unused;
        host.xfer({2'b00, a, d}, 16, unused);
    endtask
    task automatic close_out;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    initial begin
        seed = 71;
        srst_i = 1'b1;
        sleep_n = 1'b1;
        f = 16'h0000;
        repeat (10) @(posedge clk_i);
        #1 srst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        // Reset values, reserved offset included
        for (k = 0; k < 4; k++) begin
            rd((k == 3) ? 6'h0b : 6'(k), rx);
            check(rx[15:8], 8'h00);
            check(rx[7:0], 8'h00);
        end
        // Each fault alone, then random mixes; writes to status must not stick
        for (k = 0; k < 24; k++) begin
            v = (k < 16) ? (16'h0001 << k) : 16'($random(seed));
            #1 f = v;
            repeat (10) @(posedge clk_i);
            #1 f = 16'h0000;
            repeat (20) @(posedge clk_i);
            wr(6'h01, ~v[15:8]);
            rd(6'h01, rx);
            check(rx[15:8], exp_sum(v));
            check(rx[7:0], v[15:8]);
            rd(6'h02, rx);
            check(rx[7:0], exp_d2(v));
            #1 check({7'h00, err_n}, {7'h00, ~|v});
            wr(6'h06, 8'h80);
            rd(6'h00, rx);
            check(rx[15:8], 8'h00);
        end
        // Clear while the condition persists keeps that flag
        #1 f = 16'h0080;
        repeat (10) @(posedge clk_i);
        wr(6'h06, 8'h80);
        rd(6'h00, rx);
        check(rx[15:8], 8'ha0);
        #1 f = 16'h0000;
        wr(6'h06, 8'h80);
        // Extra clock pulse in a frame
        host.xfer(16'h4000, 17, rx);
        rd(6'h00, rx);
        check(rx[15:8], 8'hc0);
        #1 check({7'h00, err_n}, 8'h00);
        wr(6'h06, 8'h80);
        rd(6'h00, rx);
        check(rx[15:8], 8'h00);
        // Select held low with no clock, cleared by the sleep pin
        host.xfer(16'h4000, 0, rx);
        rd(6'h00, rx);
        check(rx[15:8], 8'hc0);
        #1 sleep_n = 1'b0;
        repeat (10) @(posedge clk_i);
        #1 sleep_n = 1'b1;
        repeat (10) @(posedge clk_i);
        rd(6'h00, rx);
        check(rx[15:8], 8'h00);
        close_out;
    end
    // Whole run needs about 22000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        close_out;
    end
endmodule
`default_nettype wire
